// *** rtl/cmd_status_pkg.sv ***
// Constants for the function command and status register pair
package cmd_status_pkg;
  localparam logic [7:0] CFG_DWORD_ADDR = 8'h04;
  localparam logic [7:0] FUNCTION_COMMAND_OFFSET = 8'h04;
  localparam logic [7:0] FUNCTION_STATUS_OFFSET = 8'h06;
  localparam logic [15:0] FUNCTION_COMMAND_RESET = 16'h0000;
  localparam logic [15:0] FUNCTION_STATUS_RESET = 16'h0010;
  localparam int LINE_IRQ_BLOCK_BIT = 10;
  localparam int MASTER_PERMIT_BIT = 2;
  localparam int MEMORY_DECODE_PERMIT_BIT = 1;
  localparam int SELECT_TIMING_LSB = 9;
  localparam logic [1:0] SELECT_TIMING_VALUE = 2'h0;
  localparam int CAPABILITY_LIST_BIT = 4;
  localparam int IRQ_PENDING_BIT = 3;
  localparam logic [15:0] COMMAND_WRITABLE_MASK = 16'h0406;
  localparam int CFG_ANSWER_CYCLES = 1;
endpackage : cmd_status_pkg

// *** rtl/cmd_if.sv ***
// Command bits and interrupt status shared by the bank and the gating core
interface cmd_if;
  logic line_irq_block;
  logic master_permit;
  logic memory_decode_permit;
  logic irq_pending;
  modport bank (
    output line_irq_block,
    output master_permit,
    output memory_decode_permit,
    input irq_pending
  );
  modport core (
    input line_irq_block,
    input master_permit,
    input memory_decode_permit,
    output irq_pending
  );
endinterface : cmd_if

// *** rtl/cmd_status_bank.sv ***
// Configuration access to the command and status registers
module cmd_status_bank
  import cmd_status_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic cfg_wr_i,
  input wire logic cfg_rd_i,
  input wire logic [7:0] cfg_addr_i,
  input wire logic [3:0] cfg_be_i,
  input wire logic [31:0] cfg_wdata_i,
  output logic [31:0] cfg_rdata_o,
  output logic cfg_ack_o,
  cmd_if.bank cif
);
  logic [15:0] cmd_q, cmd_d;
  logic [31:0] rdata_q, rdata_d;
  logic ack_q, ack_d;
  logic [15:0] be_mask;
  logic [15:0] status_word;
  logic hit;

  always_comb begin
    hit = (cfg_addr_i == CFG_DWORD_ADDR);
    be_mask = {{8{cfg_be_i[1]}}, {8{cfg_be_i[0]}}};
    // Only bits 10, 2 and 1 hold state; the rest stay zero
    cmd_d = cmd_q;
    if (cfg_wr_i && hit) begin
      cmd_d = (cmd_q & ~(be_mask & COMMAND_WRITABLE_MASK)) |
              (cfg_wdata_i[15:0] & be_mask & COMMAND_WRITABLE_MASK);
    end
    // Status is rebuilt every read; writes to its bytes are ignored
    status_word = 16'h0000;
    status_word[SELECT_TIMING_LSB +: 2] = SELECT_TIMING_VALUE;
    status_word[CAPABILITY_LIST_BIT] = 1'b1;
    status_word[IRQ_PENDING_BIT] = cif.irq_pending;
    rdata_d = 32'h0000_0000;
    if (cfg_rd_i && hit) begin
      rdata_d = {status_word, cmd_q};
    end
    ack_d = cfg_wr_i | cfg_rd_i;
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      cmd_q <= FUNCTION_COMMAND_RESET;
      rdata_q <= 32'h0000_0000;
      ack_q <= 1'b0;
    end else begin
      cmd_q <= cmd_d;
      rdata_q <= rdata_d;
      ack_q <= ack_d;
    end
  end

  assign cfg_rdata_o = rdata_q;
  assign cfg_ack_o = ack_q;
  assign cif.line_irq_block = cmd_q[LINE_IRQ_BLOCK_BIT];
  assign cif.master_permit = cmd_q[MASTER_PERMIT_BIT];
  assign cif.memory_decode_permit = cmd_q[MEMORY_DECODE_PERMIT_BIT];
endmodule : cmd_status_bank

// *** rtl/pci_function_command_status.sv ***
// Command/status pair of the host mailbox function with its gating logic
module pci_function_command_status
  import cmd_status_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic cfg_wr_i,
  input wire logic cfg_rd_i,
  input wire logic [7:0] cfg_addr_i,
  input wire logic [3:0] cfg_be_i,
  input wire logic [31:0] cfg_wdata_i,
  output logic [31:0] cfg_rdata_o,
  output logic cfg_ack_o,
  input wire logic irq_cond_i,
  input wire logic msi_req_i,
  input wire logic dma_req_i,
  input wire logic mmio_req_i,
  input wire logic fw_notify_en_i,
  output logic line_irq_o,
  output logic msi_o,
  output logic dma_grant_o,
  output logic dma_abort_o,
  output logic master_permit_o,
  output logic fw_permit_mirror_o,
  output logic fw_irq_o,
  output logic mmio_accept_o,
  output logic mmio_reject_o
);
  cmd_if cif ();

  cmd_status_bank u_bank (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .cfg_wr_i(cfg_wr_i),
    .cfg_rd_i(cfg_rd_i),
    .cfg_addr_i(cfg_addr_i),
    .cfg_be_i(cfg_be_i),
    .cfg_wdata_i(cfg_wdata_i),
    .cfg_rdata_o(cfg_rdata_o),
    .cfg_ack_o(cfg_ack_o),
    .cif(cif)
  );

  logic irq_pending_q, irq_pending_d;
  logic line_irq_q, line_irq_d;
  logic msi_q, msi_d;
  logic dma_grant_q, dma_grant_d;
  logic dma_abort_q, dma_abort_d;
  logic permit_q, permit_d;
  logic mirror_q, mirror_d;
  logic fw_irq_q, fw_irq_d;
  logic mmio_acc_q, mmio_acc_d;
  logic mmio_rej_q, mmio_rej_d;

  always_comb begin
    // Pending tracks the source alone so software can poll while blocked
    irq_pending_d = irq_cond_i;
    line_irq_d = irq_cond_i & ~cif.line_irq_block;
    // Message path looks only at the permit, never at the block bit
    msi_d = msi_req_i & cif.master_permit;
    dma_grant_d = dma_req_i & cif.master_permit;
    permit_d = cif.master_permit;
    dma_abort_d = permit_q & ~cif.master_permit;
    mirror_d = cif.master_permit;
    fw_irq_d = fw_notify_en_i & (permit_q ^ cif.master_permit);
    mmio_acc_d = mmio_req_i & cif.memory_decode_permit;
    mmio_rej_d = mmio_req_i & ~cif.memory_decode_permit;
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      irq_pending_q <= 1'b0;
      line_irq_q <= 1'b0;
      msi_q <= 1'b0;
      dma_grant_q <= 1'b0;
      dma_abort_q <= 1'b0;
      permit_q <= 1'b0;
      mirror_q <= 1'b0;
      fw_irq_q <= 1'b0;
      mmio_acc_q <= 1'b0;
      mmio_rej_q <= 1'b0;
    end else begin
      irq_pending_q <= irq_pending_d;
      line_irq_q <= line_irq_d;
      msi_q <= msi_d;
      dma_grant_q <= dma_grant_d;
      dma_abort_q <= dma_abort_d;
      permit_q <= permit_d;
      mirror_q <= mirror_d;
      fw_irq_q <= fw_irq_d;
      mmio_acc_q <= mmio_acc_d;
      mmio_rej_q <= mmio_rej_d;
    end
  end

  assign cif.irq_pending = irq_pending_q;
  assign line_irq_o = line_irq_q;
  assign msi_o = msi_q;
  assign dma_grant_o = dma_grant_q;
  assign dma_abort_o = dma_abort_q;
  assign master_permit_o = permit_q;
  assign fw_permit_mirror_o = mirror_q;
  assign fw_irq_o = fw_irq_q;
  assign mmio_accept_o = mmio_acc_q;
  assign mmio_reject_o = mmio_rej_q;

  logic rd_hit;
  assign rd_hit = cfg_rd_i && (cfg_addr_i == CFG_DWORD_ADDR);

  sequence s_rd_hit;
    rd_hit;
  endsequence

  sequence s_permit_fall;
    $fell(cif.master_permit);
  endsequence

  property p_line_block;
    @(posedge ref_clk_i) disable iff (rst_i)
    cif.line_irq_block |=> !line_irq_o;
  endproperty
  a_line_block: assert property (p_line_block)
    else $error("line interrupt while blocked");

  property p_msi_independent;
    @(posedge ref_clk_i) disable iff (rst_i)
    (msi_req_i && cif.master_permit && cif.line_irq_block) |=> msi_o;
  endproperty
  a_msi_independent: assert property (p_msi_independent)
    else $error("message interrupt lost under line block");

  property p_dma_gate;
    @(posedge ref_clk_i) disable iff (rst_i)
    dma_grant_o |-> $past(cif.master_permit) && $past(dma_req_i);
  endproperty
  a_dma_gate: assert property (p_dma_gate)
    else $error("grant without master permit");

  property p_dma_stop;
    @(posedge ref_clk_i) disable iff (rst_i)
    s_permit_fall |=> dma_abort_o && !dma_grant_o ##1 !dma_abort_o;
  endproperty
  a_dma_stop: assert property (p_dma_stop)
    else $error("DMA not stopped on permit clear");

  property p_msi_block;
    @(posedge ref_clk_i) disable iff (rst_i)
    !cif.master_permit |=> !msi_o;
  endproperty
  a_msi_block: assert property (p_msi_block)
    else $error("message interrupt with permit clear");

  property p_mirror;
    @(posedge ref_clk_i) disable iff (rst_i)
    $changed(cif.master_permit) && fw_notify_en_i
      |=> fw_irq_o && (fw_permit_mirror_o == $past(cif.master_permit));
  endproperty
  a_mirror: assert property (p_mirror)
    else $error("firmware mirror or notify wrong");

  property p_mmio;
    @(posedge ref_clk_i) disable iff (rst_i)
    mmio_req_i |=> (mmio_accept_o == $past(cif.memory_decode_permit))
      && (mmio_reject_o != mmio_accept_o);
  endproperty
  a_mmio: assert property (p_mmio)
    else $error("memory decode gating wrong");

  property p_cmd_zero;
    @(posedge ref_clk_i) disable iff (rst_i)
    s_rd_hit |=> (cfg_rdata_o[15:0] & ~COMMAND_WRITABLE_MASK) == 16'h0000;
  endproperty
  a_cmd_zero: assert property (p_cmd_zero)
    else $error("fixed command bit read nonzero");

  property p_cmd_reset;
    @(posedge ref_clk_i)
    rst_i |=> !cif.master_permit && !cif.line_irq_block
      && !cif.memory_decode_permit;
  endproperty
  a_cmd_reset: assert property (p_cmd_reset)
    else $error("command not cleared by reset");

  property p_status_fixed;
    @(posedge ref_clk_i) disable iff (rst_i)
    s_rd_hit |=> (cfg_rdata_o[31:16] & 16'hFFF7) == FUNCTION_STATUS_RESET;
  endproperty
  a_status_fixed: assert property (p_status_fixed)
    else $error("status fixed bits wrong");

  property p_irq_status;
    @(posedge ref_clk_i) disable iff (rst_i)
    (s_rd_hit ##0 irq_pending_q) |=> cfg_rdata_o[16 + IRQ_PENDING_BIT];
  endproperty
  a_irq_status: assert property (p_irq_status)
    else $error("interrupt status not shown");

  property p_irq_blocked_status;
    @(posedge ref_clk_i) disable iff (rst_i)
    (irq_cond_i && cif.line_irq_block) |=> irq_pending_q && !line_irq_o;
  endproperty
  a_irq_blocked_status: assert property (p_irq_blocked_status)
    else $error("pending lost while blocked");

  // Pending must drop again, or a polled status would never clear
  property p_irq_clear;
    @(posedge ref_clk_i) disable iff (rst_i)
    !irq_cond_i |=> !irq_pending_q;
  endproperty
  a_irq_clear: assert property (p_irq_clear)
    else $error("interrupt status stuck after clear");
endmodule : pci_function_command_status

// *** bench/testbench.sv ***
// Self-checking bench for the command and status register pair
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import cmd_status_pkg::*;

  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cfg_wr_i = 1'b0;
  logic cfg_rd_i = 1'b0;
  logic [7:0] cfg_addr_i = 8'h00;
  logic [3:0] cfg_be_i = 4'h0;
  logic [31:0] cfg_wdata_i = 32'h00000000;
  logic irq_cond_i = 1'b0;
  logic msi_req_i = 1'b0;
  logic dma_req_i = 1'b0;
  logic mmio_req_i = 1'b0;
  logic fw_notify_en_i = 1'b0;
  logic [31:0] cfg_rdata_o;
  logic cfg_ack_o, line_irq_o, msi_o, dma_grant_o, dma_abort_o;
  logic master_permit_o, fw_permit_mirror_o, fw_irq_o;
  logic mmio_accept_o, mmio_reject_o;
  int failures = 0;
  int compares = 0;
  int seed = 15950;
  logic [31:0] exp_q[$];
  logic [15:0] cmd_m = 16'h0000;
  logic [31:0] w;

  pci_function_command_status i_pci_function_command_status (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .cfg_wr_i(cfg_wr_i),
    .cfg_rd_i(cfg_rd_i), .cfg_addr_i(cfg_addr_i), .cfg_be_i(cfg_be_i),
    .cfg_wdata_i(cfg_wdata_i), .cfg_rdata_o(cfg_rdata_o),
    .cfg_ack_o(cfg_ack_o), .irq_cond_i(irq_cond_i), .msi_req_i(msi_req_i),
    .dma_req_i(dma_req_i), .mmio_req_i(mmio_req_i),
    .fw_notify_en_i(fw_notify_en_i), .line_irq_o(line_irq_o),
    .msi_o(msi_o), .dma_grant_o(dma_grant_o), .dma_abort_o(dma_abort_o),
    .master_permit_o(master_permit_o),
    .fw_permit_mirror_o(fw_permit_mirror_o), .fw_irq_o(fw_irq_o),
    .mmio_accept_o(mmio_accept_o), .mmio_reject_o(mmio_reject_o));

  always #2.5 ref_clk_i = ~ref_clk_i;

  task automatic chk(input logic [31:0] got, input logic [31:0] e,
                     input string m);
    compares++;
    if (got !== e) begin
      failures++;
      $display("[ERR] %0t %s got %h expected %h", $time, m, got, e);
    end
  endtask : chk

  // Strobe is one cycle wide; the answer is noted before it can appear
  task automatic acc(input logic wr, input logic [7:0] a,
                     input logic [3:0] be, input logic [31:0] d,
                     input logic [31:0] e);
    @(posedge ref_clk_i);
    cfg_wr_i <= wr;
    cfg_rd_i <= ~wr;
    cfg_addr_i <= a;
    cfg_be_i <= be;
    cfg_wdata_i <= d;
    exp_q.push_back(e);
    @(posedge ref_clk_i);
    cfg_wr_i <= 1'b0;
    cfg_rd_i <= 1'b0;
  endtask : acc

  task automatic wr(input logic [7:0] a, input logic [3:0] be,
                    input logic [31:0] d);
    logic [15:0] m;
    m = {{8{be[1]}}, {8{be[0]}}} & COMMAND_WRITABLE_MASK;
    if (a == CFG_DWORD_ADDR) cmd_m = (cmd_m & ~m) | (d[15:0] & m);
    acc(1'b1, a, be, d, 32'h00000000);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic irq);
    acc(1'b0, a, 4'h0, 32'h00000000, (a == CFG_DWORD_ADDR) ?
        {FUNCTION_STATUS_RESET | {12'h000, irq, 3'h0}, cmd_m} : 32'h0);
  endtask : rd

  // Every acknowledge consumes the oldest noted answer
  always @(negedge ref_clk_i) begin
    if (cfg_ack_o === 1'b1) begin
      if (exp_q.size() == 0) chk(32'h1, 32'h0, "unexpected ack");
      else chk(cfg_rdata_o, exp_q.pop_front(), "config answer");
    end
  end

  task automatic give_verdict();
    for (int i = 0; i < 20 && exp_q.size() != 0; i++) @(posedge ref_clk_i);
    if (exp_q.size() != 0) begin
      failures++;
      $display("[ERR] %0t missing acknowledge", $time);
    end
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : give_verdict

  initial begin
    repeat (50000) @(posedge ref_clk_i);
    failures++;
    $display("[ERR] %0t run did not finish", $time);
    give_verdict();
  end

  initial begin
    repeat (16) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    rd(8'h04, 1'b0);
    $display("reset values done");
    for (int i = 0; i < 12; i++) begin
      w = $random(seed);
      wr(8'h04, w[19:16], w);
      rd(8'h04, 1'b0);
    end
    // Unmapped dword must neither store nor answer with data
    wr(8'h08, 4'hF, 32'hFFFFFFFF);
    rd(8'h08, 1'b0);
    rd(8'h04, 1'b0);
    $display("register access done");
    for (int k = 0; k < 8; k++) begin
      wr(8'h04, 4'h3, {21'h0, k[2], 7'h0, k[1], k[0], 1'b0});
      @(posedge ref_clk_i);
      irq_cond_i <= 1'b1;
      msi_req_i <= 1'b1;
      dma_req_i <= 1'b1;
      mmio_req_i <= 1'b1;
      @(posedge ref_clk_i);
      @(negedge ref_clk_i);
      chk(line_irq_o, !k[2], "line irq");
      chk(msi_o, k[1], "message irq");
      chk(dma_grant_o, k[1], "dma grant");
      chk(master_permit_o, k[1], "permit out");
      chk(fw_permit_mirror_o, k[1], "mirror");
      chk(mmio_accept_o, k[0], "mmio accept");
      chk(mmio_reject_o, !k[0], "mmio reject");
      rd(8'h04, 1'b1);
      @(posedge ref_clk_i);
      irq_cond_i <= 1'b0;
      msi_req_i <= 1'b0;
      dma_req_i <= 1'b0;
      mmio_req_i <= 1'b0;
    end
    $display("gating done");
    for (int n = 0; n < 2; n++) begin
      wr(8'h04, 4'h1, 32'h00000004);
      @(posedge ref_clk_i);
      dma_req_i <= 1'b1;
      fw_notify_en_i <= n[0];
      wr(8'h04, 4'h1, 32'h00000000);
      @(posedge ref_clk_i);
      @(negedge ref_clk_i);
      chk(dma_abort_o, 1'b1, "abort pulse");
      chk(dma_grant_o, 1'b0, "grant after clear");
      chk(fw_irq_o, n[0], "firmware notify");
      @(negedge ref_clk_i);
      chk(dma_abort_o, 1'b0, "abort one cycle");
      @(posedge ref_clk_i);
      dma_req_i <= 1'b0;
    end
    $display("permit clear done");
    // A second reset mid-run must clear stored command bits again
    wr(8'h04, 4'hF, 32'hFFFFFFFF);
    @(posedge ref_clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    cmd_m = 16'h0000;
    rd(8'h04, 1'b0);
    $display("second reset done");
    give_verdict();
  end
endmodule : testbench
